// file: hdl/serial_dac_write_port.sv
// Write-only three-wire serial port of a single-channel converter, both
// the wide (24-bit frame) and narrow (16-bit frame) variants.
// Assumes frame_sel_n, sclk and sdata come from pins in another domain;
// ref_clk must run well above the serial clock (bench: 800 ns sclk).
`timescale 1ns/1ns
`include "serial_dac_consts.svh"

// Behaviour
// - Wide: sample data on falling edges.
// - Wide: execute on the 24th edge.
// - Narrow: execute on the 16th edge.
// - New frame only on select falling edge.
// - Wide: two mode bits, 16 data bits.
// - Narrow: two mode bits, 14 data bits.
// - Mode bits pick normal or power-down.
// - Mode decode; narrow 11 is software reset.
// - Early select rise discards the frame.
// - Power-down keeps the output code.
// - Power-on loads midscale or zero code.
// - Full scale ffff wide, 3fff narrow.
// - Thermometer 4 MSBs, 12 ladder bits.
module serial_dac_write_port
#(
   parameter bit WIDE_VARIANT = 1'b1,
   parameter bit RESET_MID    = 1'b1
)
(
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   input  wire logic        frame_sel_n,
   input  wire logic        sclk,
   input  wire logic        sdata,
   output logic      [15:0] code_out,
   output logic      [1:0]  power_mode,
   output logic             powerdown_mode_hi,
   output logic             powerdown_mode_lo,
   output logic             output_enable,
   output logic      [14:0] segment_switch,
   output logic      [11:0] ladder_switch,
   output logic             update_pulse
);
   ////////////////////////////////////////////////////////////////////
   // Variant dependent figures.
   localparam logic [4:0]  FRAME_BITS = WIDE_VARIANT ?
      `WIDE_FRAME_BITS : `NARROW_FRAME_BITS;
   localparam logic [15:0] FULL_SCALE = WIDE_VARIANT ?
      `WIDE_FULL_SCALE : `NARROW_FULL_SCALE;
   localparam logic [15:0] MID_SCALE = WIDE_VARIANT ?
      `WIDE_MID_SCALE : `NARROW_MID_SCALE;
   localparam logic [15:0] RESET_CODE = RESET_MID ?
      MID_SCALE : `ZERO_CODE;

   typedef struct packed
   {
      logic [1:0]  sel_sync;
      logic [1:0]  clk_sync;
      logic [1:0]  dat_sync;
      logic        sel_prev;
      logic        clk_prev;
      serial_dac_pkg::frame_state_type state;
      logic [4:0]  count;
      logic [23:0] shift;
      logic [15:0] code;
      logic [1:0]  mode;
      logic        update;
   } state_type;

   state_type state_reg;
   state_type state_next;

   logic sel_s;
   logic clk_s;
   logic dat_s;
   logic sel_fall;
   logic sel_rise;
   logic clk_fall;
   logic [23:0] word;

   assign sel_s = state_reg.sel_sync[1];
   assign clk_s = state_reg.clk_sync[1];
   assign dat_s = state_reg.dat_sync[1];
   assign sel_fall = state_reg.sel_prev & ~sel_s;
   assign sel_rise = ~state_reg.sel_prev & sel_s;
   assign clk_fall = state_reg.clk_prev & ~clk_s;
   assign word = {state_reg.shift[22:0], dat_s};

   ////////////////////////////////////////////////////////////////////
   // Next state: synchronisers, edge finding and the frame sequencer.
   // Sampling on the synchronised edge costs two ref_clk cycles of
   // latency, which is why ref_clk must outpace sclk by a margin.
   always_comb
   begin
      state_next = state_reg;
      state_next.sel_sync = {state_reg.sel_sync[0], frame_sel_n};
      state_next.clk_sync = {state_reg.clk_sync[0], sclk};
      state_next.dat_sync = {state_reg.dat_sync[0], sdata};
      state_next.sel_prev = sel_s;
      state_next.clk_prev = clk_s;
      state_next.update = 1'b0;
      case (state_reg.state)
         serial_dac_pkg::FRAME_IDLE:
         begin
            if (sel_fall)
            begin
               state_next.state = serial_dac_pkg::FRAME_SHIFT;
               state_next.count = 5'h00;
               state_next.shift = 24'h000000;
            end
         end
         serial_dac_pkg::FRAME_SHIFT:
         begin
            if (sel_rise)
            begin
               // Aborted frame leaves code and mode alone.
               state_next.state = serial_dac_pkg::FRAME_IDLE;
               state_next.shift = 24'h000000;
            end
            else if (clk_fall)
            begin
               state_next.shift = word;
               state_next.count = state_reg.count + 5'h01;
               if (state_reg.count == FRAME_BITS - 5'h01)
               begin
                  state_next.state = serial_dac_pkg::FRAME_DONE;
                  state_next.update = 1'b1;
                  if (WIDE_VARIANT)
                  begin
                     state_next.mode = word[`WIDE_MODE_HI_POS -: 2];
                     // A power-down word only changes the mode.
                     if (word[`WIDE_MODE_HI_POS -: 2] == `MODE_NORMAL)
                     begin
                        state_next.code = word[15:0];
                     end
                  end
                  else if (word[`NARROW_MODE_HI_POS -: 2] ==
                           `MODE_LOAD_1K)
                  begin
                     // Software reset returns to power-on state.
                     state_next.mode = `MODE_NORMAL;
                     state_next.code = RESET_CODE;
                  end
                  else
                  begin
                     state_next.mode = word[`NARROW_MODE_HI_POS -: 2];
                     if (word[`NARROW_MODE_HI_POS -: 2] == `MODE_NORMAL)
                     begin
                        state_next.code = {2'h0, word[13:0]};
                     end
                  end
               end
            end
         end
         serial_dac_pkg::FRAME_DONE:
         begin
            if (sel_s)
            begin
               state_next.state = serial_dac_pkg::FRAME_IDLE;
            end
         end
         default:
         begin
            state_next.state = serial_dac_pkg::FRAME_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // State register; synchronisers start at the idle pin levels.
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         state_reg <= '{sel_sync: 2'h3, clk_sync: 2'h3, dat_sync: 2'h0,
            sel_prev: 1'b1, clk_prev: 1'b1,
            state: serial_dac_pkg::FRAME_IDLE, count: 5'h00,
            shift: 24'h000000, code: RESET_CODE,
            mode: `MODE_NORMAL, update: 1'b0};
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs. Power-down only gates the stage, never the code.
   assign code_out = state_reg.code;
   assign power_mode = state_reg.mode;
   assign powerdown_mode_hi = state_reg.mode[1];
   assign powerdown_mode_lo = state_reg.mode[0];
   assign output_enable = (state_reg.mode == `MODE_NORMAL);
   assign update_pulse = state_reg.update;

   segment_decoder segment_decoder_i
   (
      .code           (state_reg.code),
      .segment_switch (segment_switch),
      .ladder_switch  (ladder_switch)
   );

   ////////////////////////////////////////////////////////////////////
   // Assertions.
   property p_abort_keeps_code;
      @(posedge ref_clk) disable iff (!nrst)
      (state_reg.state == serial_dac_pkg::FRAME_SHIFT && sel_rise)
         |=> $stable(state_reg.code) && $stable(state_reg.mode);
   endproperty
   a_abort_keeps_code: assert property (p_abort_keeps_code)
      else $error("Aborted frame changed code or mode.");

   property p_update_on_last;
      @(posedge ref_clk) disable iff (!nrst)
      state_reg.update |-> state_reg.count == FRAME_BITS;
   endproperty
   a_update_on_last: assert property (p_update_on_last)
      else $error("Update not on the final falling edge.");

   property p_code_only_on_update;
      @(posedge ref_clk) disable iff (!nrst)
      !state_next.update |=> $stable(state_reg.code);
   endproperty
   a_code_only_on_update: assert property (p_code_only_on_update)
      else $error("Code changed outside an update.");

   // A completed power-down word must leave the held code in place.
   property p_powerdown_keeps_code;
      @(posedge ref_clk) disable iff (!nrst)
      (state_reg.update && state_reg.mode != `MODE_NORMAL)
         |-> $stable(state_reg.code);
   endproperty
   a_powerdown_keeps_code: assert property (p_powerdown_keeps_code)
      else $error("Power-down write changed the code.");

   property p_done_ignores;
      @(posedge ref_clk) disable iff (!nrst)
      state_reg.state == serial_dac_pkg::FRAME_DONE
         |=> !state_reg.update && $stable(state_reg.shift);
   endproperty
   a_done_ignores: assert property (p_done_ignores)
      else $error("Edge after completion caused an update.");

   property p_start_on_fall;
      @(posedge ref_clk) disable iff (!nrst)
      (state_reg.state == serial_dac_pkg::FRAME_IDLE && !sel_fall)
         |=> state_reg.state == serial_dac_pkg::FRAME_IDLE;
   endproperty
   a_start_on_fall: assert property (p_start_on_fall)
      else $error("Frame began without a select falling edge.");

   property p_shift_in;
      @(posedge ref_clk) disable iff (!nrst)
      (state_reg.state == serial_dac_pkg::FRAME_SHIFT && !sel_rise
         && clk_fall) |=> state_reg.shift[0] == $past(dat_s);
   endproperty
   a_shift_in: assert property (p_shift_in)
      else $error("Data bit not shifted in on falling edge.");

   property p_range;
      @(posedge ref_clk) disable iff (!nrst)
      state_reg.code <= FULL_SCALE;
   endproperty
   a_range: assert property (p_range)
      else $error("Code above full scale.");

   property p_enable;
      @(posedge ref_clk) disable iff (!nrst)
      output_enable == (power_mode == `MODE_NORMAL);
   endproperty
   a_enable: assert property (p_enable)
      else $error("Output enable disagrees with mode.");

   c_update: cover property (@(posedge ref_clk) state_reg.update);
   c_abort: cover property (@(posedge ref_clk)
      state_reg.state == serial_dac_pkg::FRAME_SHIFT && sel_rise);
   c_powerdown: cover property (@(posedge ref_clk)
      state_reg.mode != `MODE_NORMAL);
endmodule

// file: hdl/serial_dac_consts.svh
// Constants of the serial converter write port: frame lengths, field
// positions, reset codes and mode encodings. Included by bare name.
`ifndef SERIAL_DAC_CONSTS_SVH
`define SERIAL_DAC_CONSTS_SVH
`define WIDE_FRAME_BITS    5'h18
`define NARROW_FRAME_BITS  5'h10
`define WIDE_CODE_BITS     16
`define NARROW_CODE_BITS   14
`define WIDE_MODE_HI_POS   17
`define NARROW_MODE_HI_POS 15
`define WIDE_FULL_SCALE    16'hffff
`define NARROW_FULL_SCALE  16'h3fff
`define ZERO_CODE          16'h0000
`define WIDE_MID_SCALE     16'h8000
`define NARROW_MID_SCALE   16'h2000
`define MODE_NORMAL        2'h0
`define MODE_TRISTATE      2'h1
`define MODE_LOAD_100K     2'h2
`define MODE_LOAD_1K       2'h3
`define SEG_MSB_BITS       4
`define SEG_SWITCHES       15
`define LADDER_BITS        12
`endif

// file: hdl/serial_dac_pkg.sv
// Types shared by the serial converter write port.
// Assumes the constants header is included before use.
package serial_dac_pkg;
   typedef enum logic [1:0]
   {
      FRAME_IDLE  = 2'h0,
      FRAME_SHIFT = 2'h1,
      FRAME_DONE  = 2'h3
   } frame_state_type;
endpackage

// file: hdl/segment_decoder.sv
// Thermometer decoder for the segmented string of the converter core.
// Assumes a registered output code at its input; purely combinational.
`timescale 1ns/1ns
`include "serial_dac_consts.svh"
module segment_decoder
(
   input  wire logic [15:0] code,
   output logic      [14:0] segment_switch,
   output logic      [11:0] ladder_switch
);
   ////////////////////////////////////////////////////////////////////
   // Top four bits switch in that many segments; the rest go straight
   // to the ladder so the string stays monotonic.
   always_comb
   begin
      for (int i = 0; i < `SEG_SWITCHES; i++)
      begin
         segment_switch[i] = (code[15:12] > 4'(i));
      end
      ladder_switch = code[11:0];
   end
endmodule

// file: bench/host_model.sv
// Host model: drives frame select, serial clock and data of one port.
// Assumes send is called just after a rising edge of the 100 ns clock.
`timescale 1ns/1ns
module host_model
(
   output logic frame_sel_n,
   output logic sclk,
   output logic sdata
);
   // The serial clock parks high outside frames; select idles high.
   initial
   begin
      frame_sel_n = 1'b1;
      sclk        = 1'b1;
      sdata       = 1'b0;
   end

   // Sends the low n bits of w with sent clocks; fewer clocks abort.
   task automatic send(input logic [23:0] w, input int n, input int sent,
                       input bit keep);
      int i;
      #1;
      if (frame_sel_n == 1'b0)
      begin
         frame_sel_n = 1'b1;
         #400;
      end
      frame_sel_n = 1'b0;
      #400;
      for (i = 0; i < sent; i++)
      begin
         sdata = (i < n) ? w[n - 1 - i] : ~sdata;
         #400 sclk = 1'b0;
         #400 sclk = 1'b1;
      end
      // Released data toggles, so a stale bit never looks valid.
      sdata = ~sdata;
      if (!keep)
         frame_sel_n = 1'b1;
      #399;
   endtask
endmodule

// file: bench/tb_serial_dac_write_port.sv
// Self-checking bench for the serial converter write port.
// Assumes one wide instance (midscale reset), one narrow (zero reset).
`timescale 1ns/1ns
module tb_serial_dac_write_port;
   logic        ref_clk = 1'b0;
   logic        nrst    = 1'b0;
   logic        sel_w, clk_w, dat_w, sel_n, clk_n, dat_n;
   logic [15:0] code_w, code_n;
   logic [1:0]  mode_w, mode_n;
   logic        hi_w, lo_w, oe_w, upd_w, upd_n;
   logic [14:0] seg_w;
   logic [11:0] lad_w;
   int          fail_count  = 0;
   int          checks_done = 0;
   int          pw = 0;
   int          pn = 0;

   host_model host_w (.frame_sel_n(sel_w), .sclk(clk_w), .sdata(dat_w));
   host_model host_n (.frame_sel_n(sel_n), .sclk(clk_n), .sdata(dat_n));
   serial_dac_write_port #(.WIDE_VARIANT(1'b1), .RESET_MID(1'b1))
   serial_dac_write_port_i (.ref_clk(ref_clk), .nrst(nrst),
      .frame_sel_n(sel_w), .sclk(clk_w), .sdata(dat_w), .code_out(code_w),
      .power_mode(mode_w), .powerdown_mode_hi(hi_w),
      .powerdown_mode_lo(lo_w), .output_enable(oe_w),
      .segment_switch(seg_w), .ladder_switch(lad_w), .update_pulse(upd_w));
   serial_dac_write_port #(.WIDE_VARIANT(1'b0), .RESET_MID(1'b0))
   serial_dac_write_port_n_i (.ref_clk(ref_clk), .nrst(nrst),
      .frame_sel_n(sel_n), .sclk(clk_n), .sdata(dat_n), .code_out(code_n),
      .power_mode(mode_n), .powerdown_mode_hi(), .powerdown_mode_lo(),
      .output_enable(), .segment_switch(), .ladder_switch(),
      .update_pulse(upd_n));

   ////////////////////////////////////////////////////////////////////////
   // Clock and a count of update pulses per instance.
   always #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      if (upd_w === 1'b1)
         pw <= pw + 1;
      if (upd_n === 1'b1)
         pn <= pn + 1;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // One frame, then a bounded wait for the expected number of updates.
   task automatic frame(input bit nar, input logic [23:0] w, input int n,
                        input int sent, input bit keep, input int exp_p);
      int p0;
      int k;
      p0 = nar ? pn : pw;
      if (nar)
         host_n.send(w, n, sent, keep);
      else
         host_w.send(w, n, sent, keep);
      for (k = 0; k < 20 && (nar ? pn : pw) - p0 < exp_p; k++)
         @(posedge ref_clk);
      if (k == 20)
      begin
         fail_count++;
         tally_and_finish();
      end
      repeat (12) @(posedge ref_clk);
      check((nar ? pn : pw) - p0, exp_p);
   endtask

   task automatic wide_state(input logic [15:0] c, input logic [1:0] m);
      check(code_w, c);
      check(mode_w, m);
      check({hi_w, lo_w}, m);
      check(oe_w, m == 2'h0);
      check(seg_w, 32'h7fff >> (15 - c[15:12]));
      check(lad_w, c[11:0]);
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      wide_state(16'h8000, 2'h0);
      check(code_n, 16'h0000);
      check(mode_n, 2'h0);
   endtask

   // Every mode code; power-down writes must leave the code alone.
   task automatic t_wide_modes();
      frame(1'b0, {6'h2a, 2'h0, 16'hffff}, 24, 24, 1'b0, 1);
      wide_state(16'hffff, 2'h0);
      for (int m = 1; m < 4; m++)
      begin
         frame(1'b0, {6'h15, m[1:0], 16'h1234}, 24, 24, 1'b0, 1);
         wide_state(16'hffff, m[1:0]);
      end
      frame(1'b0, {6'h00, 2'h0, 16'h5a5a}, 24, 24, 1'b0, 1);
      wide_state(16'h5a5a, 2'h0);
   endtask

   // Abort one edge short, then a frame with select held and extra clocks.
   task automatic t_wide_abort_keep();
      frame(1'b0, {8'h00, 16'h0f0f}, 24, 23, 1'b0, 0);
      wide_state(16'h5a5a, 2'h0);
      frame(1'b0, {8'h00, 16'hc3c3}, 24, 48, 1'b1, 1);
      wide_state(16'hc3c3, 2'h0);
      frame(1'b0, {8'h00, 16'h0001}, 24, 24, 1'b0, 1);
      wide_state(16'h0001, 2'h0);
   endtask

   task automatic t_narrow();
      frame(1'b1, 24'h002a5c, 16, 16, 1'b0, 1);
      check(code_n, 16'h2a5c);
      frame(1'b1, 24'h003fff, 16, 16, 1'b0, 1);
      check(code_n, 16'h3fff);
      frame(1'b1, 24'h001555, 16, 15, 1'b0, 0);
      check(code_n, 16'h3fff);
      for (int m = 1; m < 3; m++)
      begin
         frame(1'b1, {8'h00, m[1:0], 14'h0123}, 16, 16, 1'b0, 1);
         check(mode_n, m[1:0]);
         check(code_n, 16'h3fff);
      end
      frame(1'b1, 24'h00ffff, 16, 16, 1'b0, 1);
      check(code_n, 16'h0000);
      check(mode_n, 2'h0);
   endtask

   // Main sequence; reset is released just after an edge.
   initial
   begin
      repeat (6) @(posedge ref_clk);
      #1 nrst = 1'b1;
      repeat (4) @(posedge ref_clk);
      t_reset();
      t_wide_modes();
      t_wide_abort_keep();
      t_narrow();
      tally_and_finish();
   end
endmodule
